//--- verilog/fault_status_word.sv
// fault_status_word: bus-fault status word logic of the core, with an apb window for handlers.
// assumes: cycle attributes and strobes come from the bus controller, synchronous to pclk;
// the register window is zero-wait apb on the same clock.
// one fault is held at a time; a strobe while busy is dropped.
//
// Behaviour
// - frame class bit 15: exception faults one
// - multi-move flag bit 14, also on fetch
// - original size in bits 13 and 5
// - bit 12 pending trace; re-armed on return
// - breakpoint pending bits 11, 10 always stacked
// - rerun flag bit 9; rerun write on return
// - bit 8 atomic cycle, ignored on return
// - bit 7 prefetch class, ignored on return
// - bit 6 direction, reloaded when rerunning
// - remaining size field, reloaded on rerun
// - space code copied, reloaded on rerun
// - unused bits zero, ignored on return
// - four fault classes
// - released write fault taken at boundary
// - operand access while pending aborts unless at a boundary, takes fault
// - released write fixed pattern of status bits
// - released write stacks pc, sr, address, data
// - prefetch, reads, atomic, peripheral are other class
// - other class aborts now, restores address registers
// - other class stacks trace zero, breaks kept
// - atomic fault sets flag, direction shows phase
`timescale 1ns/1ns
module fault_status_word (
	input  wire                              pclk,            // core clock, 50 mhz
	input  wire                              presetn,         // async reset, low

	// apb slave
	input  wire                              psel,
	input  wire                              penable,
	input  wire                              pwrite,
	input  wire  [7:0]                       paddr,
	input  wire  [31:0]                      pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,

	// from the bus controller and sequencer
	input  wire                              fault_strobe,    // one-cycle fault event
	input  wire  fault_word_pkg::cycle_attr_t cycle_attr,     // faulted cycle
	input  wire  fault_word_pkg::pend_t      pend_now,        // pending exceptions
	input  wire  [31:0]                      fault_addr,      // faulted address
	input  wire  [31:0]                      fault_data,      // write data buffer
	input  wire  [31:0]                      pc_now,          // pc of next unexecuted insn
	input  wire  [15:0]                      sr_now,          // current status register
	input  wire                              insn_boundary,   // instruction boundary reached
	input  wire                              operand_access,  // next insn wants an operand

	// to the sequencer and bus controller
	output logic                             abort_insn,      // abort current instruction
	output logic                             restore_regs,    // undo address-mode updates
	output logic                             fault_take,      // exception processing starts
	output logic                             frame_valid,     // frame held for handler
	output logic                             rerun_req,       // rerun the stacked write
	output logic                             rerun_dir,       // direction for the rerun
	output logic [1:0]                       rerun_size,      // size for the rerun
	output logic [2:0]                       rerun_space,     // space code for the rerun
	output logic                             requeue_trace,   // re-arm pending trace
	output logic                             requeue_ext_brk, // re-arm external breakpoint
	output logic                             requeue_int_brk  // re-arm internal breakpoint
);
	// encoder input and results
	fault_word_pkg::fault_type_t enc_type;      // class of the selected cycle
	logic [15:0]                 enc_word;      // word of the selected cycle
	fault_word_pkg::cycle_attr_t enc_attr;      // cycle handed to the encoder

	// fsm and frame state
	fault_word_pkg::fault_state_t state_r, state_nxt;
	fault_word_pkg::fault_type_t  type_r, type_nxt;

	// frame captured at the fault or at the take
	fault_word_pkg::cycle_attr_t  attr_r, attr_nxt;   // held attributes while pending
	logic [15:0]                  word_r, word_nxt;   // stacked status word
	logic [31:0]                  addr_r, addr_nxt;   // stacked fault address
	logic [31:0]                  data_r, data_nxt;   // stacked data buffer
	logic [31:0]                  pc_r, pc_nxt;       // stacked pc
	logic [15:0]                  sr_r, sr_nxt;       // stacked sr

	// pulse outputs and rerun attributes
	logic       abort_r, abort_nxt;
	logic       restore_r, restore_nxt;
	logic       take_r, take_nxt;

	logic       rerun_r, rerun_nxt;

	// rerun attributes, held until the next return with the rerun bit set
	logic       rdir_r, rdir_nxt;
	logic [1:0] rsize_r, rsize_nxt;
	logic [2:0] rspace_r, rspace_nxt;

	// requeue pulses after a return
	logic [2:0] requeue_r, requeue_nxt;           // trace, ext, int

	// apb decode
	logic apb_access;    // access phase
	logic apb_wr;        // write takes effect this edge
	logic hit_word;      // status word write
	logic hit_return;    // exception return command
	logic addr_known;    // mapped offset

	// pending released write uses the held cycle; otherwise the live one
	assign enc_attr = (state_r == fault_word_pkg::ST_PENDING) ? attr_r : cycle_attr;

	// classification and word assembly
	fault_word_encode u_encode (
		.attr  (enc_attr),
		.pend  (pend_now),
		.ftype (enc_type),
		.word  (enc_word)
	);

	// map: 00 word, 04 address, 08 data, 0c pc, 10 sr,
	// 14 control (bit 0 returns), 18 state; unmapped
	// offsets raise pslverr, read-only words drop writes

	// apb decode; zero wait states so a transfer is always two cycles
	always_comb begin
		apb_access = psel && penable;
		apb_wr     = apb_access && pwrite;

		hit_word   = 1'b0;
		hit_return = 1'b0;
		addr_known = 1'b1;

		// writes act only in the access phase
		if (paddr == fault_word_pkg::OFS_STATUS_WORD) begin
			hit_word = apb_wr;
		end else if (paddr == fault_word_pkg::OFS_CONTROL) begin
			hit_return = apb_wr && pwdata[fault_word_pkg::CTRL_RETURN_BIT];
		end else if (paddr == fault_word_pkg::OFS_FAULT_ADDR) begin
			addr_known = 1'b1;
		end else if (paddr == fault_word_pkg::OFS_DATA_BUF) begin
			addr_known = 1'b1;
		end else if (paddr == fault_word_pkg::OFS_STACKED_PC) begin
			addr_known = 1'b1;
		end else if (paddr == fault_word_pkg::OFS_STACKED_SR) begin
			addr_known = 1'b1;
		end else if (paddr == fault_word_pkg::OFS_STATE) begin
			addr_known = 1'b1;
		end else begin
			addr_known = 1'b0; // unmapped: error, reads zero
		end
	end

	// apb answer, read mux over frame flops; upper bits of narrow registers read zero
	always_comb begin
		pready  = 1'b1;
		pslverr = apb_access && !addr_known;
		prdata  = fault_word_pkg::REG_RESET;

		// data only in the access phase of a read
		if (apb_access && !pwrite) begin
			if (paddr == fault_word_pkg::OFS_STATUS_WORD) begin
				prdata = {16'h0000, word_r};
			end else if (paddr == fault_word_pkg::OFS_FAULT_ADDR) begin
				prdata = addr_r;
			end else if (paddr == fault_word_pkg::OFS_DATA_BUF) begin
				prdata = data_r;
			end else if (paddr == fault_word_pkg::OFS_STACKED_PC) begin
				prdata = pc_r;
			end else if (paddr == fault_word_pkg::OFS_STACKED_SR) begin
				prdata = {16'h0000, sr_r};
			end else if (paddr == fault_word_pkg::OFS_STATE) begin
				prdata = {26'h0000000, state_r, 2'h0, type_r};
			end else begin
				prdata = fault_word_pkg::REG_RESET;
			end
		end
	end

	// fault sequencing and frame capture
	always_comb begin
		// frame holds unless a fault or the handler moves it
		state_nxt   = state_r;
		type_nxt    = type_r;
		attr_nxt    = attr_r;
		word_nxt    = word_r;
		addr_nxt    = addr_r;
		data_nxt    = data_r;
		pc_nxt      = pc_r;
		sr_nxt      = sr_r;

		// pulses fall back to zero every cycle
		abort_nxt   = 1'b0;
		restore_nxt = 1'b0;
		take_nxt    = 1'b0;
		rerun_nxt   = 1'b0;

		// rerun attributes hold between returns
		rdir_nxt    = rdir_r;
		rsize_nxt   = rsize_r;
		rspace_nxt  = rspace_r;
		requeue_nxt = 3'h0;

		case (state_r)
			fault_word_pkg::ST_IDLE: begin
				if (fault_strobe) begin
					// capture the cycle now, the bus moves on
					type_nxt = enc_type;
					attr_nxt = cycle_attr;
					addr_nxt = fault_addr;
					data_nxt = fault_data;

					if (enc_type == fault_word_pkg::FT_RELEASED) begin
						// overlapped write: let the current insn run to its end
						state_nxt = fault_word_pkg::ST_PENDING;
					end else begin
						// every other class aborts at once
						word_nxt    = enc_word;
						pc_nxt      = pc_now;
						sr_nxt      = sr_now;
						abort_nxt   = 1'b1;
						take_nxt    = 1'b1;

						// only a restartable fault undoes increments
						restore_nxt = (enc_type == fault_word_pkg::FT_OTHER);
						state_nxt   = fault_word_pkg::ST_STACKED;
					end
				end
			end

			fault_word_pkg::ST_PENDING: begin
				if (insn_boundary || operand_access) begin
					// pending bits sampled when the fault is finally taken
					word_nxt  = enc_word;
					pc_nxt    = pc_now; // next unexecuted insn
					sr_nxt    = sr_now;
					take_nxt  = 1'b1;

					// stale data hazard: kill the accessing insn
					abort_nxt = operand_access && !insn_boundary;
					state_nxt = fault_word_pkg::ST_STACKED;
				end
			end

			fault_word_pkg::ST_STACKED: begin
				// handler may rewrite the word, e.g. clear rerun
				if (hit_word) begin
					word_nxt = pwdata[15:0];
				end

				if (hit_return) begin
					// unstack: only rerun, direction, size, space and pending bits matter;
					// atomic, prefetch, class and unused bits are disregarded
					rerun_nxt  = word_r[fault_word_pkg::BIT_RERUN];
					// without rerun the bus controller keeps its old attributes
					if (word_r[fault_word_pkg::BIT_RERUN]) begin
						rdir_nxt   = word_r[fault_word_pkg::BIT_DIR];
						rsize_nxt  = word_r[fault_word_pkg::BIT_REM_HI:fault_word_pkg::BIT_REM_LO];
						rspace_nxt = word_r[fault_word_pkg::BIT_SPACE_HI:fault_word_pkg::BIT_SPACE_LO];
					end

					requeue_nxt = {word_r[fault_word_pkg::BIT_TRACE],
						word_r[fault_word_pkg::BIT_EXT_BREAK],
						word_r[fault_word_pkg::BIT_INT_BREAK]}; // pending trace and breaks re-armed from the word
					state_nxt = fault_word_pkg::ST_IDLE;
				end
			end

			default: begin
				state_nxt = fault_word_pkg::ST_IDLE; // unused code recovers to idle
			end
		endcase
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= fault_word_pkg::ST_IDLE;
			type_r    <= fault_word_pkg::FT_RELEASED;

			attr_r    <= '0;
			word_r    <= fault_word_pkg::WORD_RESET;
			addr_r    <= fault_word_pkg::REG_RESET;
			data_r    <= fault_word_pkg::REG_RESET;
			pc_r      <= fault_word_pkg::REG_RESET;
			sr_r      <= fault_word_pkg::WORD_RESET;
		end else begin
			state_r   <= state_nxt;
			type_r    <= type_nxt;

			attr_r    <= attr_nxt;
			word_r    <= word_nxt;
			addr_r    <= addr_nxt;
			data_r    <= data_nxt;
			pc_r      <= pc_nxt;
			sr_r      <= sr_nxt;
		end
	end

	// pulse registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_r   <= 1'b0;
			restore_r <= 1'b0;
			take_r    <= 1'b0;
			rerun_r   <= 1'b0;
			requeue_r <= 3'h0;
		end else begin
			abort_r   <= abort_nxt;
			restore_r <= restore_nxt;
			take_r    <= take_nxt;
			rerun_r   <= rerun_nxt;
			requeue_r <= requeue_nxt;
		end
	end

	// rerun attributes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdir_r    <= 1'b0;
			rsize_r   <= fault_word_pkg::SIZE_LONG;
			rspace_r  <= 3'h0;
		end else begin
			rdir_r    <= rdir_nxt;
			rsize_r   <= rsize_nxt;
			rspace_r  <= rspace_nxt;
		end
	end

	// outputs straight from flops
	assign abort_insn      = abort_r;
	assign restore_regs    = restore_r;
	assign fault_take      = take_r;

	// level: high from the take to the return
	assign frame_valid     = (state_r == fault_word_pkg::ST_STACKED);

	// rerun pulse and the attributes that go with it
	assign rerun_req       = rerun_r;
	assign rerun_dir       = rdir_r;
	assign rerun_size      = rsize_r;
	assign rerun_space     = rspace_r;

	// requeue pulses, one cycle after a return
	assign requeue_trace   = requeue_r[2];
	assign requeue_ext_brk = requeue_r[1];
	assign requeue_int_brk = requeue_r[0];
endmodule

//--- verilog/fault_word_pkg.sv
// fault_word_pkg: constants, types and the register map of the bus-fault status logic.
// assumes: included before every file of this block; nothing is imported, all uses are scoped.
package fault_word_pkg;
	// apb byte offsets, one aligned word each
	localparam logic [7:0] OFS_STATUS_WORD = 8'h00; // stacked fault status word, r/w
	localparam logic [7:0] OFS_FAULT_ADDR  = 8'h04; // faulted address, ro
	localparam logic [7:0] OFS_DATA_BUF    = 8'h08; // data buffer of the write, ro
	localparam logic [7:0] OFS_STACKED_PC  = 8'h0c; // stacked program counter, ro
	localparam logic [7:0] OFS_STACKED_SR  = 8'h10; // stacked status register, ro
	localparam logic [7:0] OFS_CONTROL     = 8'h14; // write bit 0: exception return
	localparam logic [7:0] OFS_STATE       = 8'h18; // block state, ro
	// fault status word bit positions
	localparam int BIT_CLASS      = 15; // frame class
	localparam int BIT_MULTI      = 14; // multi-register move
	localparam int BIT_ORIG_HI    = 13; // original size, high
	localparam int BIT_TRACE      = 12; // deferred step
	localparam int BIT_EXT_BREAK  = 11; // external breakpoint
	localparam int BIT_INT_BREAK  = 10; // internal breakpoint
	localparam int BIT_RERUN      = 9;  // rerun write
	localparam int BIT_ATOMIC     = 8;  // read-modify-write
	localparam int BIT_PREFETCH   = 7;  // prefetch class
	localparam int BIT_DIR        = 6;  // 1 read/prefetch, 0 write
	localparam int BIT_ORIG_LO    = 5;  // original size, low
	localparam int BIT_REM_HI     = 4;  // remaining size field
	localparam int BIT_REM_LO     = 3;
	localparam int BIT_SPACE_HI   = 2;  // space code field
	localparam int BIT_SPACE_LO   = 0;
	// size encodings
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	// reset values
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [31:0] REG_RESET  = 32'h0000_0000;
	localparam int          CTRL_RETURN_BIT = 0;

	// four fault classes
	typedef enum logic [1:0] {
		FT_RELEASED  = 2'b00, // released write
		FT_EXCEPTION = 2'b01, // during exception processing
		FT_MULTI     = 2'b10, // multi-move operand transfer
		FT_OTHER     = 2'b11  // every other cycle
	} fault_type_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00, // no fault outstanding
		ST_PENDING = 2'b01, // released write fault waits for a boundary
		ST_STACKED = 2'b10  // frame held for the handler
	} fault_state_t;

	// attributes of the faulted bus cycle, from the bus controller
	typedef struct packed {
		logic       released_write; // overlapped final write
		logic       in_exception;   // exception stacking cycle
		logic       multi_xfer;     // multi-move operand transfer
		logic       multi_fetch;    // prefetch of a multi-move opcode/extension
		logic       prefetch;       // instruction prefetch
		logic       atomic;         // part of a read-modify-write
		logic       read;           // 1 read, 0 write
		logic [1:0] orig_size;      // size of the first cycle
		logic [1:0] rem_size;       // size still to go
		logic [2:0] space;          // space code lines
	} cycle_attr_t;

	// exceptions pending at fault time
	typedef struct packed {
		logic trace;
		logic ext_break;
		logic int_break;
	} pend_t;
endpackage

//--- verilog/fault_word_encode.sv
// fault_word_encode: classifies a fault and assembles its status word.
// assumes: pure combinational leaf, driven by the fault status top.
`timescale 1ns/1ns
module fault_word_encode (
	input  wire fault_word_pkg::cycle_attr_t attr,  // faulted cycle
	input  wire fault_word_pkg::pend_t       pend,  // pending exceptions
	output fault_word_pkg::fault_type_t      ftype, // class of the fault
	output logic [15:0]                      word   // status word
);
	// classification, exception stacking wins over all others
	always_comb begin
		if (attr.in_exception) begin
			ftype = fault_word_pkg::FT_EXCEPTION;
		end else if (attr.released_write) begin
			ftype = fault_word_pkg::FT_RELEASED; // last multi/peripheral write lands here
		end else if (attr.multi_xfer && !attr.prefetch) begin
			ftype = fault_word_pkg::FT_MULTI;
		end else begin
			ftype = fault_word_pkg::FT_OTHER; // prefetch, reads, atomic, peripheral moves
		end
	end

	// word assembly; every bit not named stays zero
	always_comb begin
		word = fault_word_pkg::WORD_RESET;
		word[fault_word_pkg::BIT_ORIG_HI] = attr.orig_size[1];
		word[fault_word_pkg::BIT_ORIG_LO] = attr.orig_size[0];
		word[fault_word_pkg::BIT_REM_HI:fault_word_pkg::BIT_REM_LO] = attr.rem_size;
		word[fault_word_pkg::BIT_SPACE_HI:fault_word_pkg::BIT_SPACE_LO] = attr.space;
		word[fault_word_pkg::BIT_EXT_BREAK] = pend.ext_break; // every class
		word[fault_word_pkg::BIT_INT_BREAK] = pend.int_break;
		word[fault_word_pkg::BIT_TRACE] = pend.trace;
		case (ftype)
			fault_word_pkg::FT_EXCEPTION: begin
				word[fault_word_pkg::BIT_CLASS] = 1'b1;
				word[fault_word_pkg::BIT_DIR] = 1'b1;
			end
			fault_word_pkg::FT_RELEASED: begin
				word[fault_word_pkg::BIT_RERUN] = 1'b1; // class, atomic, prefetch, dir zero
			end
			fault_word_pkg::FT_MULTI: begin
				word[fault_word_pkg::BIT_MULTI] = 1'b1;
				word[fault_word_pkg::BIT_RERUN] = !attr.read; // write faults rerun
				word[fault_word_pkg::BIT_DIR] = attr.read;
			end
			default: begin
				word[fault_word_pkg::BIT_TRACE] = 1'b0; // instruction restarts
				word[fault_word_pkg::BIT_MULTI] = attr.multi_fetch;
				word[fault_word_pkg::BIT_ATOMIC] = attr.atomic;
				word[fault_word_pkg::BIT_PREFETCH] = attr.prefetch;
				word[fault_word_pkg::BIT_DIR] = attr.read | attr.prefetch;
			end
		endcase
	end
endmodule

//--- bench/fault_status_word_monitor.sv
// fault_status_word_monitor: port assertions for the bus-fault status word block.
// assumes: bound to fault_status_word; one pclk domain, presetn asynchronous and low.
`timescale 1ns/1ns
module fault_status_word_monitor (
	input wire                              pclk,
	input wire                              presetn,
	input wire                              psel,
	input wire                              penable,
	input wire                              pwrite,
	input wire [7:0]                        paddr,
	input wire [31:0]                       pwdata,
	input wire [31:0]                       prdata,
	input wire                              fault_strobe,
	input wire fault_word_pkg::cycle_attr_t cycle_attr,
	input wire                              insn_boundary,
	input wire                              operand_access,
	input wire                              abort_insn,
	input wire                              restore_regs,
	input wire                              fault_take,
	input wire                              frame_valid,
	input wire                              rerun_req,
	input wire                              requeue_trace
);
	logic pend_r;   // released write fault waiting for its boundary
	logic pend_nxt; // next value of pend_r
	logic idle;     // no fault outstanding, strobes are accepted
	logic ret_hit;  // exception return accepted this cycle
	logic fresh;    // non-exception strobe that the block must take
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign idle = !frame_valid && !pend_r;
	assign fresh = fault_strobe && idle && !cycle_attr.in_exception;
	assign ret_hit = psel && penable && pwrite && pwdata[0] && frame_valid
		&& paddr == fault_word_pkg::OFS_CONTROL;
	// track the pending state, the block does not show it on a pin
	always_comb begin
		pend_nxt = pend_r;
		if (fault_take)
			pend_nxt = 1'b0;
		else if (fresh && cycle_attr.released_write)
			pend_nxt = 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pend_r <= 1'b0;
		else
			pend_r <= pend_nxt;
	end
	sequence s_other;
		fresh && !cycle_attr.released_write && !(cycle_attr.multi_xfer && !cycle_attr.prefetch);
	endsequence
	sequence s_taken;
		fault_take && frame_valid;
	endsequence
	property p_other;
		s_other |=> s_taken and (abort_insn && restore_regs);
	endproperty
	a_other: assert property (p_other) else $error("other fault not aborted");
	property p_excep;
		fault_strobe && idle && cycle_attr.in_exception |=> s_taken ##0 !restore_regs;
	endproperty
	a_excep: assert property (p_excep) else $error("exception fault mishandled");
	property p_multi;
		fresh && !cycle_attr.released_write && cycle_attr.multi_xfer && !cycle_attr.prefetch
			|=> s_taken ##0 (abort_insn && !restore_regs);
	endproperty
	a_multi: assert property (p_multi) else $error("multi move fault mishandled");
	property p_wait;
		fresh && cycle_attr.released_write |=> !fault_take && !abort_insn;
	endproperty
	a_wait: assert property (p_wait) else $error("released write taken early");
	property p_boundary;
		pend_r && insn_boundary && !fault_take |=> s_taken ##0 !abort_insn;
	endproperty
	a_boundary: assert property (p_boundary) else $error("boundary did not take");
	property p_operand;
		pend_r && operand_access && !insn_boundary && !fault_take |=> s_taken ##0 abort_insn;
	endproperty
	a_operand: assert property (p_operand) else $error("operand access not aborted");
	property p_return;
		ret_hit |=> !frame_valid;
	endproperty
	a_return: assert property (p_return) else $error("frame kept after return");
	property p_cause;
		rerun_req || requeue_trace |-> $past(ret_hit);
	endproperty
	a_cause: assert property (p_cause) else $error("rerun without return");
	property p_hold;
		frame_valid && !ret_hit |=> frame_valid;
	endproperty
	a_hold: assert property (p_hold) else $error("frame dropped");
	property p_upper;
		psel && penable && !pwrite && paddr == fault_word_pkg::OFS_STATUS_WORD
			|-> prdata[31:16] == 16'h0000;
	endproperty
	a_upper: assert property (p_upper) else $error("unused word bits set");
endmodule

bind fault_status_word fault_status_word_monitor mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .fault_strobe(fault_strobe), .cycle_attr(cycle_attr),
	.insn_boundary(insn_boundary), .operand_access(operand_access), .abort_insn(abort_insn),
	.restore_regs(restore_regs), .fault_take(fault_take), .frame_valid(frame_valid),
	.rerun_req(rerun_req), .requeue_trace(requeue_trace));

//--- bench/testbench.sv
// testbench: random bus faults of all four classes, handler edits and returns.
// assumes: zero-wait apb slave on pclk; one fault outstanding at a time.
`timescale 1ns/1ns
module testbench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = '0, prdata, fault_addr = '0, fault_data = '0, pc_now = '0, rd;
	logic [15:0] sr_now = 16'h0000;
	logic pready, pslverr, err, fault_strobe = 1'b0, insn_boundary = 1'b0, operand_access = 1'b0;
	fault_word_pkg::cycle_attr_t cycle_attr = '0;
	fault_word_pkg::pend_t pend_now = '0;
	logic abort_insn, restore_regs, fault_take, frame_valid, rerun_req, rerun_dir;
	logic [1:0] rerun_size;
	logic [2:0] rerun_space;
	logic requeue_trace, requeue_ext_brk, requeue_int_brk;
	int n_errors = 0; // mismatches seen
	int comparisons = 0; // compares made
	// 50 mhz core clock
	always #10 pclk = ~pclk;
	fault_status_word uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fault_strobe(fault_strobe), .cycle_attr(cycle_attr),
		.pend_now(pend_now), .fault_addr(fault_addr), .fault_data(fault_data), .pc_now(pc_now),
		.sr_now(sr_now), .insn_boundary(insn_boundary), .operand_access(operand_access),
		.abort_insn(abort_insn), .restore_regs(restore_regs), .fault_take(fault_take),
		.frame_valid(frame_valid), .rerun_req(rerun_req), .rerun_dir(rerun_dir),
		.rerun_size(rerun_size), .rerun_space(rerun_space), .requeue_trace(requeue_trace),
		.requeue_ext_brk(requeue_ext_brk), .requeue_int_brk(requeue_int_brk));
	task automatic conclude();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// compare with case equality so an unknown never matches
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one apb transfer; read data and error are taken at the pready edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) begin
			n_errors++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// status word the block should stack, class priority as the note gives it
	function automatic logic [15:0] exp_word(input fault_word_pkg::cycle_attr_t c,
		input fault_word_pkg::pend_t p);
		logic ex, rel, mul, oth;
		ex = c.in_exception;
		rel = !ex && c.released_write;
		mul = !ex && !rel && c.multi_xfer && !c.prefetch;
		oth = !ex && !rel && !mul;
		return {ex, mul | (oth & c.multi_fetch), c.orig_size[1], p.trace & !oth, p.ext_break,
			p.int_break, rel | (mul & !c.read), oth & c.atomic, oth & c.prefetch,
			ex | ((mul | oth) & (c.read | c.prefetch)), c.orig_size[0], c.rem_size, c.space};
	endfunction
	initial begin
		fault_word_pkg::cycle_attr_t c;
		fault_word_pkg::pend_t p;
		logic [31:0] v[4];
		logic [15:0] w;
		logic bnd;
		int k;
		void'($urandom(32'hf32ff1a2));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// corners: unmapped read, word write refused while idle
		apb(1'b0, 8'h1c, '0);
		chk("unmapped", {31'h0, err}, 32'h1);
		apb(1'b1, fault_word_pkg::OFS_STATUS_WORD, 32'hffff_ffff);
		apb(1'b0, fault_word_pkg::OFS_STATUS_WORD, '0);
		chk("idle word", rd, '0);
		for (int i = 0; i < 80; i++) begin
			k = i % 4; // every class in turn, attributes random
			c = 15'($urandom);
			p = 3'($urandom);
			c.released_write = (k == 0);
			c.in_exception = (k == 1);
			c.multi_fetch = c.multi_fetch & c.prefetch;
			c.multi_xfer = (k == 2) || (k == 3 && c.multi_fetch);
			if (k == 0 || k == 2)
				c.prefetch = 1'b0;
			if (k == 0)
				c.read = 1'b0;
			c.orig_size = 2'($urandom % 3);
			c.rem_size = (c.orig_size == fault_word_pkg::SIZE_LONG && c.space[0]) ?
				fault_word_pkg::SIZE_WORD : c.orig_size;
			foreach (v[j])
				v[j] = $urandom;
			v[3][31:16] = 16'h0000;
			@(posedge pclk);
			fault_strobe <= 1'b1;
			cycle_attr <= c;
			pend_now <= p;
			fault_addr <= v[0];
			fault_data <= v[1];
			pc_now <= v[2];
			sr_now <= v[3][15:0];
			@(posedge pclk);
			fault_strobe <= 1'b0;
			#1;
			chk("pulses", {29'h0, abort_insn, restore_regs, fault_take},
				{29'h0, k != 0, k == 3, k != 0});
			if (k == 0) begin
				bnd = 1'($urandom);
				@(posedge pclk);
				insn_boundary <= bnd;
				operand_access <= !bnd || 1'($urandom);
				@(posedge pclk);
				insn_boundary <= 1'b0;
				operand_access <= 1'b0;
				#1;
				chk("late take", {30'h0, abort_insn, fault_take}, {30'h0, !bnd, 1'b1});
			end
			for (int j = 0; j < 4; j++) begin
				apb(1'b0, 8'(4 + 4 * j), '0);
				chk("frame", rd, v[j]);
			end
			apb(1'b0, fault_word_pkg::OFS_STATE, '0);
			chk("state", rd, {26'h0, 2'h2, 2'h0, k == 0 ? 2'h0 : k == 1 ? 2'h1 : k == 2 ?
				2'h2 : 2'h3});
			w = exp_word(c, p);
			apb(1'b0, fault_word_pkg::OFS_STATUS_WORD, '0);
			chk("word", rd, {16'h0, w});
			// handler edits ignored bits and may finish the write itself
			w[8:7] = w[8:7] ^ 2'($urandom);
			if (1'($urandom))
				w[9] = 1'b0;
			apb(1'b1, fault_word_pkg::OFS_STATUS_WORD, {16'h0, w});
			apb(1'b1, fault_word_pkg::OFS_CONTROL, 32'h1);
			#1;
			chk("return", {27'h0, rerun_req, requeue_trace, requeue_ext_brk, requeue_int_brk,
				frame_valid}, {27'h0, w[9], w[12], w[11], w[10], 1'b0});
			if (w[9])
				chk("rerun", {26'h0, rerun_dir, rerun_size, rerun_space}, {26'h0, w[6], w[4:0]});
		end
		conclude();
	end
endmodule
